// ---- design/bcr_config_regs.v ----
// Functional notes
// - The spread width bit selects 200 kHz deviation when clear and 300 kHz when set.
// - Bit zero of the clock register selects converter clock when clear, charge-pump when set.
// - Both registers load their programmed defaults on power-on reset and on no other reset.
// - The five upper bits of the clock register read zero and ignore writes.
//
// Purpose: Third converter ramp, protection and clock configuration register bank
// Assumes: Serial bus engine delivers one-cycle write strobes and takes registered read data one edge after the read strobe
// Notes:   Overvoltage event sets the latch; set wins over a clearing write
`timescale 1ns/1ps
`include "bcr_defines.vh"
module bcr_config_regs (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire       eng_mode_i,
    input  wire       ovp_event_i,
    input  wire       bypass_req_i,
    input  wire       wr_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    output reg        overvoltage_latch_o,
    output reg        fast_down_ramp_enable_o,
    output reg        down_ramp_assist_enable_o,
    output reg        up_ramp_assist_enable_o,
    output reg        bypass_enable_o,
    output reg        fast_on_highside_enable_o,
    output reg        slow_off_highside_enable_o,
    output reg  [1:0] ramp_threshold_select_o,
    output reg        spread_width_select_o,
    output reg  [9:0] spread_deviation_khz_o,
    output reg        spread_spectrum_enable_o,
    output reg        oscillator_source_select_o
);
    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire       ramp_wr  = wr_i && (addr_i == `BCR_ADDR_RAMP_PROTECT);
    wire       clock_wr = wr_i && (addr_i == `BCR_ADDR_CLOCK_SPREAD);
    wire [7:0] ramp_mask  = `BCR_RAMP_USER_MASK
                          | (eng_mode_i ? `BCR_RAMP_ENG_MASK : 8'h00);
    wire [7:0] clock_mask = eng_mode_i ? `BCR_CLOCK_ENG_MASK : 8'h00;
    wire [7:0] ramp_q;
    wire [7:0] clock_q;

    // Latch bit kept apart so a hardware set can beat a clearing write
    reg        ovp_reg;
    wire       ovp_next = ovp_event_i ? 1'b1
                        : (ramp_wr ? wdata_i[`BCR_OVP_BIT] : ovp_reg);

    // ----------------------------------------
    // Storage, power-on reset only
    // ----------------------------------------
    bcr_cfg_reg #(.RST_VAL(`BCR_RAMP_PROTECT_RST)) u_ramp (
        .sys_clk_i (sys_clk_i),
        .por_i     (rst_i),
        .wr_i      (ramp_wr),
        .wmask_i   (ramp_mask & ~(8'h01 << `BCR_OVP_BIT)),
        .wdata_i   (wdata_i),
        .q_o       (ramp_q)
    );
    bcr_cfg_reg #(.RST_VAL(`BCR_CLOCK_SPREAD_RST)) u_clock (
        .sys_clk_i (sys_clk_i),
        .por_i     (rst_i),
        .wr_i      (clock_wr),
        .wmask_i   (clock_mask),
        .wdata_i   (wdata_i),
        .q_o       (clock_q)
    );

    wire [7:0] ramp_view = {ovp_next, ramp_q[6:0]};

    // ----------------------------------------
    // Latch, registered outputs and readback
    // ----------------------------------------
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovp_reg                    <= `BCR_OVP_RST;
            rdata_o                    <= 8'h00;
            overvoltage_latch_o        <= 1'b0;
            fast_down_ramp_enable_o    <= 1'b0;
            down_ramp_assist_enable_o  <= 1'b0;
            up_ramp_assist_enable_o    <= 1'b0;
            bypass_enable_o            <= 1'b0;
            fast_on_highside_enable_o  <= 1'b0;
            slow_off_highside_enable_o <= 1'b0;
            ramp_threshold_select_o    <= 2'h3;
            spread_width_select_o      <= 1'b1;
            spread_deviation_khz_o     <= `BCR_SPREAD_WIDE_KHZ;
            spread_spectrum_enable_o   <= 1'b0;
            oscillator_source_select_o <= 1'b1;
        end else begin
            ovp_reg                    <= ovp_next;
            overvoltage_latch_o        <= ovp_next;
            fast_down_ramp_enable_o    <= ramp_view[`BCR_FAST_DOWN_BIT];
            // Gated here so a late OVP cannot leave assist on for a cycle
            down_ramp_assist_enable_o  <= ramp_view[`BCR_DOWN_ASSIST_BIT] & ~ovp_next;
            up_ramp_assist_enable_o    <= ramp_view[`BCR_UP_ASSIST_BIT] & ~ovp_next;
            bypass_enable_o            <= bypass_req_i & ~ovp_next;
            fast_on_highside_enable_o  <= ramp_view[`BCR_FAST_ON_BIT];
            slow_off_highside_enable_o <= ramp_view[`BCR_SLOW_OFF_BIT];
            ramp_threshold_select_o    <= ramp_view[1:0];
            spread_width_select_o      <= clock_q[`BCR_SPREAD_WIDTH_BIT];
            spread_deviation_khz_o     <= clock_q[`BCR_SPREAD_WIDTH_BIT]
                                        ? `BCR_SPREAD_WIDE_KHZ : `BCR_SPREAD_NARROW_KHZ;
            spread_spectrum_enable_o   <= clock_q[`BCR_SPREAD_EN_BIT];
            oscillator_source_select_o <= clock_q[`BCR_OSC_SRC_BIT];
            if (rd_i) begin
                case (addr_i)
                    `BCR_ADDR_RAMP_PROTECT: rdata_o <= {ovp_reg, ramp_q[6:0]};
                    `BCR_ADDR_CLOCK_SPREAD: rdata_o <= {5'h00, clock_q[2:0]};
                    default:                rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ---- design/bcr_defines.vh ----
// Purpose: Constants for the third converter ramp, protect and clock configuration registers
// Assumes: Register index on an 8-bit address, 8-bit data
// Notes:   Defaults are the one-time-programmed values
`ifndef BCR_DEFINES_VH
`define BCR_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCR_ADDR_RAMP_PROTECT   8'h12
`define BCR_ADDR_CLOCK_SPREAD   8'h13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BCR_RAMP_PROTECT_RST    8'h03
`define BCR_CLOCK_SPREAD_RST    8'h05
`define BCR_OVP_RST             1'b0

// ----------------------------------------
// Field positions, ramp/protect register
// ----------------------------------------
`define BCR_OVP_BIT             7
`define BCR_FAST_DOWN_BIT       6
`define BCR_DOWN_ASSIST_BIT     5
`define BCR_UP_ASSIST_BIT       4
`define BCR_FAST_ON_BIT         3
`define BCR_SLOW_OFF_BIT        2
// Engineering-only fields: fast down, fast on, slow off, threshold
`define BCR_RAMP_ENG_MASK       8'h4f
// Always writable: overvoltage latch, down and up assist
`define BCR_RAMP_USER_MASK      8'hb0

// ----------------------------------------
// Field positions, clock/spread register
// ----------------------------------------
`define BCR_SPREAD_WIDTH_BIT    2
`define BCR_SPREAD_EN_BIT       1
`define BCR_OSC_SRC_BIT         0
`define BCR_CLOCK_ENG_MASK      8'h07

// ----------------------------------------
// Spread widths, kHz
// ----------------------------------------
`define BCR_SPREAD_NARROW_KHZ   10'd200
`define BCR_SPREAD_WIDE_KHZ     10'd300

`endif

// ---- design/bcr_cfg_reg.v ----
// Purpose: One 8-bit configuration register with per-bit write mask
// Assumes: Power-on reset is the only reset reaching it
// Notes:   Bits outside the writable mask keep their current value
`timescale 1ns/1ps
module bcr_cfg_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    input  wire       sys_clk_i,
    input  wire       por_i,
    input  wire       wr_i,
    input  wire [7:0] wmask_i,
    input  wire [7:0] wdata_i,
    output reg  [7:0] q_o
);
    always @(posedge sys_clk_i or posedge por_i) begin
        if (por_i) begin
            q_o <= RST_VAL;
        end else if (wr_i) begin
            q_o <= (q_o & ~wmask_i) | (wdata_i & wmask_i);
        end
    end
endmodule

// ---- sim/bcr_config_properties.sv ----
// Purpose: Port-level checks on the converter config bank
// Assumes: Fields follow a write by two edges
// Notes:   Power-on reset disables every check
`timescale 1ns/1ps
module bcr_config_props (
    input wire       sys_clk_i, rst_i, eng_mode_i, ovp_event_i, wr_i, rd_i,
    input wire [7:0] addr_i, wdata_i, rdata_o,
    input wire       overvoltage_latch_o, down_ramp_assist_enable_o, up_ramp_assist_enable_o,
    input wire       bypass_enable_o, fast_on_highside_enable_o, spread_width_select_o,
    input wire       oscillator_source_select_o,
    input wire [1:0] ramp_threshold_select_o,
    input wire [9:0] spread_deviation_khz_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_ovp_forces_off;
        overvoltage_latch_o |-> !(bypass_enable_o || up_ramp_assist_enable_o
                                  || down_ramp_assist_enable_o);
    endproperty
    a_ovp_forces_off: assert property (p_ovp_forces_off) else $error("assist on in latch");
    property p_ovp_sets;
        ovp_event_i |=> overvoltage_latch_o;
    endproperty
    a_ovp_sets: assert property (p_ovp_sets) else $error("latch not set");
    property p_width_dev;
        spread_deviation_khz_o == (spread_width_select_o ? 10'd300 : 10'd200);
    endproperty
    a_width_dev: assert property (p_width_dev) else $error("deviation mismatch");
    property p_osc_write;
        wr_i && addr_i == 8'h13 && eng_mode_i |=> ##1
            oscillator_source_select_o == $past(wdata_i[0], 2);
    endproperty
    a_osc_write: assert property (p_osc_write) else $error("osc source not written");
    property p_por_defaults;
        $past(rst_i) |-> ramp_threshold_select_o == 2'b11 && oscillator_source_select_o
                         && spread_width_select_o;
    endproperty
    a_por_defaults: assert property (p_por_defaults) else $error("bad reset value");
    property p_rsvd_zero;
        rd_i && addr_i == 8'h13 |=> rdata_o[7:3] == 5'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
    // Holds even with an engineering write to 0x12 just before; only the write itself is compared
    property p_eng_locked;
        wr_i && addr_i == 8'h12 && !eng_mode_i |=> ##1 $stable(ramp_threshold_select_o)
            && $stable(fast_on_highside_enable_o);
    endproperty
    a_eng_locked: assert property (p_eng_locked) else $error("locked field changed");
    c_ovp: cover property (ovp_event_i);
    c_eng_wr: cover property (wr_i && eng_mode_i);
    c_rd13: cover property (rd_i && addr_i == 8'h13);
endmodule
bind bcr_config_regs bcr_config_props bcr_config_props_inst (.*);

// ---- sim/tb_top.sv ----
// Purpose: Directed test of the converter config bank
// Assumes: Reads answer one edge after the strobe
// Notes:   Bus tasks drive on rising edges only
`timescale 1ns/1ps
module tb_top;
    reg        sys_clk_i = 0, rst_i = 1, eng_mode_i = 0, ovp_event_i = 0, bypass_req_i = 0;
    reg        wr_i = 0, rd_i = 0;
    reg  [7:0] addr_i = 8'h00, wdata_i = 8'h00;
    wire [7:0] rdata_o;
    wire [1:0] ramp_threshold_select_o;
    wire [9:0] spread_deviation_khz_o;
    wire       overvoltage_latch_o, fast_down_ramp_enable_o, down_ramp_assist_enable_o;
    wire       up_ramp_assist_enable_o, bypass_enable_o, fast_on_highside_enable_o;
    wire       slow_off_highside_enable_o, spread_width_select_o, spread_spectrum_enable_o;
    wire       oscillator_source_select_o;
    integer    mismatches = 0, tests_run = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    bcr_config_regs bcr_config_regs_inst (.*);
    task chk(input [9:0] seen, input [9:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Two spare edges let the field outputs settle
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_i); wr_i <= 1; addr_i <= a; wdata_i <= d;
            @(posedge sys_clk_i); wr_i <= 0;
            repeat (2) @(posedge sys_clk_i);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge sys_clk_i); rd_i <= 1; addr_i <= a;
            @(posedge sys_clk_i); rd_i <= 0;
            #1 chk(rdata_o, e);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #20000 mismatches = mismatches + 1;
        conclude;
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 0;
        rd(8'h12, 8'h03);
        rd(8'h13, 8'h05);
        chk(spread_deviation_khz_o, 10'd300);
        wr(8'h12, 8'h30); rd(8'h12, 8'h33);
        wr(8'h13, 8'h00); rd(8'h13, 8'h05);
        rd(8'h20, 8'h00);
        eng_mode_i <= 1;
        wr(8'h13, 8'hfa); rd(8'h13, 8'h02);
        chk(oscillator_source_select_o, 10'd0);
        chk(spread_deviation_khz_o, 10'd200);
        chk({spread_width_select_o, spread_spectrum_enable_o}, 10'h001);
        wr(8'h12, 8'h4d); rd(8'h12, 8'h4d);
        chk({fast_down_ramp_enable_o, down_ramp_assist_enable_o, up_ramp_assist_enable_o,
             fast_on_highside_enable_o, slow_off_highside_enable_o,
             ramp_threshold_select_o}, 10'h04d);
        bypass_req_i <= 1;
        repeat (3) @(posedge sys_clk_i) #1;
        chk(bypass_enable_o, 10'd1);
        @(posedge sys_clk_i) ovp_event_i <= 1;
        @(posedge sys_clk_i) ovp_event_i <= 0;
        @(posedge sys_clk_i) #1;
        chk({overvoltage_latch_o, bypass_enable_o, up_ramp_assist_enable_o,
             down_ramp_assist_enable_o}, 10'h008);
        wr(8'h12, 8'h30); #1;
        chk({overvoltage_latch_o, bypass_enable_o, up_ramp_assist_enable_o,
             down_ramp_assist_enable_o}, 10'h007);
        @(posedge sys_clk_i) rst_i <= 1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 0;
        rd(8'h12, 8'h03);
        conclude;
    end
endmodule
